// [common/mahi_pkg.sv]
package mahi_pkg;

    // ****************************************************************
    // instruction decode
    // ****************************************************************
    localparam logic [5:0] XFER_OPCODE = 6'h38;
    localparam logic [5:0] DEVICE_CODE = 6'h0B;
    localparam logic [5:0] FN_SKIP     = 6'h01;
    localparam logic [5:0] FN_READ     = 6'h02;
    localparam logic [5:0] FN_START    = 6'h04;
    localparam logic [5:0] FN_STATUS   = 6'h22;
    localparam logic [5:0] FN_CLEAR    = 6'h32;

    // ****************************************************************
    // word layout
    // ****************************************************************
    localparam int WORD_W      = 18;
    localparam int RESULT_W    = 13;
    localparam int CHAN_W      = 7;
    localparam int GAIN_W      = 2;
    localparam int ST_CHAN_LSB = 0;
    localparam int ST_GAIN_LSB = 7;
    localparam int ST_EXT_BIT  = 9;
    localparam int ST_CS_BIT   = 10;
    localparam int ST_SEQ_BIT  = 11;
    localparam int ST_ATM_BIT  = 12;
    localparam int ST_PGM_BIT  = 13;
    localparam int ST_PRI_BIT  = 14;
    localparam int IS_BUF_BIT  = 15;
    localparam int IS_BUSY_BIT = 16;
    localparam int IS_DONE_BIT = 17;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [CHAN_W-1:0] CHAN_RST = 7'h00;
    localparam logic [GAIN_W-1:0] GAIN_RST = 2'h0;
    localparam logic [WORD_W-1:0] WORD_RST = 18'h00000;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CONV_PERIOD_NS  = 40000;
    localparam int CONV_PERIOD_CYC = (CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PACE_W          = 12;
    localparam int BUF_DEPTH       = 2;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_ARM  = 3'b010,
        ST_CONV = 3'b100
    } mahi_state_t;

endpackage : mahi_pkg

// [core/mahi_buf.sv]
`timescale 1ns/1ps
module mahi_buf
#(
    parameter int WIDTH = 18
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    // ****************************************************************
    // shift storage, head always in slot 0
    // ****************************************************************
    logic [WIDTH-1:0] mem_q [mahi_pkg::BUF_DEPTH];
    logic [WIDTH-1:0] mem_d [mahi_pkg::BUF_DEPTH];
    logic             vld_q [mahi_pkg::BUF_DEPTH];
    logic             vld_d [mahi_pkg::BUF_DEPTH];
    logic             placed;

    assign out_valid = vld_q[0];
    assign out_data  = mem_q[0];
    // full only when every slot is taken
    assign in_ready  = !vld_q[mahi_pkg::BUF_DEPTH-1];

    always_comb
    begin
        placed = 1'b0;
        for (int i = 0; i < mahi_pkg::BUF_DEPTH; i++)
        begin
            mem_d[i] = mem_q[i];
            vld_d[i] = vld_q[i];
        end
        if (out_ready && vld_q[0])
        begin
            for (int i = 0; i < mahi_pkg::BUF_DEPTH - 1; i++)
            begin
                mem_d[i] = mem_q[i+1];
                vld_d[i] = vld_q[i+1];
            end
            vld_d[mahi_pkg::BUF_DEPTH-1] = 1'b0;
        end
        if (in_valid && in_ready)
        begin
            for (int i = 0; i < mahi_pkg::BUF_DEPTH; i++)
            begin
                if (!vld_d[i] && !placed)
                begin
                    mem_d[i] = in_data;
                    vld_d[i] = 1'b1;
                    placed   = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        for (int i = 0; i < mahi_pkg::BUF_DEPTH; i++)
        begin
            mem_q[i] <= mem_d[i];
            vld_q[i] <= rst ? 1'b0 : vld_d[i];
        end
    end

endmodule : mahi_buf

// [core/mahi_pace.sv]
`timescale 1ns/1ps
module mahi_pace
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic restart,
    output logic      ready
);
    // ****************************************************************
    // minimum spacing between converter starts
    // ****************************************************************
    localparam logic [mahi_pkg::PACE_W-1:0] LOAD = mahi_pkg::PACE_W'(mahi_pkg::CONV_PERIOD_CYC - 1);

    logic [mahi_pkg::PACE_W-1:0] cnt_q;
    logic [mahi_pkg::PACE_W-1:0] cnt_d;
    logic                        rdy_q;
    logic                        rdy_d;

    assign ready = rdy_q;

    always_comb
    begin
        cnt_d = cnt_q;
        rdy_d = rdy_q;
        if (restart)
        begin
            cnt_d = LOAD;
            rdy_d = 1'b0;
        end
        else if (cnt_q != '0)
        begin
            cnt_d = cnt_q - 1'b1;
            rdy_d = (cnt_q == 12'h001);
        end
        else
        begin
            rdy_d = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

endmodule : mahi_pace

// [core/mahi_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// [R01] act only on instructions with device code 13 octal
// [R02] instruction is opcode 70, device/subdevice field and timing pulse bits
// [R03] host loads status word in accumulator, then sends it by start instruction
// [R04] status word decoded into gain, channel and operating mode
// [R05] seven-bit channel address picks one of 128 inputs
// [R06] two-bit gain code picks gain 1, 2, 4 or 8
// [R07] result is 13-bit two's complement, right-justified, sign extended
// [R08] converter done pulse ends conversion and releases result
// [R09] internal sync starts converter itself; external sync uses sync input
// [R10] program mode: read instructions return result or status to accumulator
// [R11] data channel mode: request cycle steals carrying result to memory
// [R12] data channel runs sequential or random channel order
// [R13] add-to-memory flag sums result into memory word
// [R14] raise program or priority interrupt when service is needed
// [R15] starts spaced to allow 25,000 conversions per second; code spaces starts at least 4001 clocks (40.01 us) apart
// [R16] start is 701304, read result is 701302
// [R17] read status is 701342, clear flags is 701362
// [R18] 701301 skips when completion flag is set
// [R19] done pulse sets sticky flag until clear instruction
// [R20] sequential mode steps channel after each completed conversion
module mahi_top
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        xfer_strobe,
    input  wire logic [17:0] io_transfer_instruction,
    input  wire logic [17:0] ac_in,
    output logic      [17:0] ac_out,
    output logic             ac_out_valid,
    output logic             skip_req,
    output logic             program_interrupt,
    output logic             priority_interrupt,
    output logic             cycle_steal_req,
    output logic      [17:0] cycle_steal_data,
    output logic             cycle_steal_add,
    input  wire logic        cycle_steal_ack,
    output logic      [6:0]  mux_channel,
    output logic      [1:0]  gain_sel,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [12:0] conv_result,
    input  wire logic        ext_sync
);
    // ****************************************************************
    // instruction decode
    // ****************************************************************
    function automatic logic fn_is(input logic [17:0] w, input logic [5:0] code);
        return w[5:0] == code;
    endfunction : fn_is

    logic sel;
    logic cmd_start;
    logic cmd_read;
    logic cmd_status;
    logic cmd_clear;
    logic cmd_skip;

    assign sel = xfer_strobe && io_transfer_instruction[17:12] == mahi_pkg::XFER_OPCODE
                 && io_transfer_instruction[11:6] == mahi_pkg::DEVICE_CODE; // [R01] [R02]
    assign cmd_start  = sel && fn_is(io_transfer_instruction, mahi_pkg::FN_START);  // [R16] [R03]
    assign cmd_read   = sel && fn_is(io_transfer_instruction, mahi_pkg::FN_READ);   // [R16]
    assign cmd_status = sel && fn_is(io_transfer_instruction, mahi_pkg::FN_STATUS); // [R17]
    assign cmd_clear  = sel && fn_is(io_transfer_instruction, mahi_pkg::FN_CLEAR);  // [R17]
    assign cmd_skip   = sel && fn_is(io_transfer_instruction, mahi_pkg::FN_SKIP);   // [R18]

    // ****************************************************************
    // state
    // ****************************************************************
    mahi_pkg::mahi_state_t state_q;
    mahi_pkg::mahi_state_t state_d;
    logic [6:0]  chan_q;
    logic [6:0]  chan_d;
    logic [1:0]  gain_q;
    logic [1:0]  gain_d;
    logic        ext_q;
    logic        ext_d;
    logic        steal_q;
    logic        steal_d;
    logic        seq_q;
    logic        seq_d;
    logic        atm_q;
    logic        atm_d;
    logic        pgm_en_q;
    logic        pgm_en_d;
    logic        pri_en_q;
    logic        pri_en_d;
    logic        done_q;
    logic        done_d;
    logic        start_q;
    logic        start_d;
    logic        sync_prev_q;
    logic        pend_q;
    logic        pend_d;
    logic [17:0] pend_data_q;
    logic [17:0] pend_data_d;
    logic [17:0] ac_q;
    logic [17:0] ac_d;
    logic        ac_vld_q;
    logic        ac_vld_d;
    logic        skip_q;
    logic        skip_d;
    logic        pgm_irq_q;
    logic        pri_irq_q;
    logic        cs_req_q;
    logic        cs_req_d;
    logic [17:0] cs_data_q;
    logic [17:0] cs_data_d;
    logic        cs_add_q;
    logic        cs_add_d;

    logic        pace_ok;
    logic        buf_in_ready;
    logic        buf_out_valid;
    logic [17:0] buf_out_data;
    logic        buf_pop;
    logic        cs_take;
    logic        sync_fire;
    logic        done_evt;
    logic [17:0] status_word;

    // ****************************************************************
    // helpers
    // ****************************************************************
    mahi_pace u_pace
    (
        .clk     (clk),
        .rst     (rst),
        .restart (start_q),
        .ready   (pace_ok)
    );

    // a stalled cycle steal must not lose a finished word
    mahi_buf #(.WIDTH(mahi_pkg::WORD_W)) u_buf
    (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (pend_q),
        .in_data   (pend_data_q),
        .in_ready  (buf_in_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_data),
        .out_ready (buf_pop)
    );

    assign sync_fire = ext_q ? (ext_sync && !sync_prev_q) : 1'b1; // [R09]
    assign done_evt  = conv_done && state_q == mahi_pkg::ST_CONV; // [R08]
    assign cs_take   = buf_out_valid && steal_q && !cs_req_q;     // [R11]
    assign buf_pop   = cs_take || (cmd_read && buf_out_valid && !steal_q);

    always_comb
    begin
        status_word = mahi_pkg::WORD_RST;
        status_word[mahi_pkg::ST_CHAN_LSB +: mahi_pkg::CHAN_W] = chan_q;
        status_word[mahi_pkg::ST_GAIN_LSB +: mahi_pkg::GAIN_W] = gain_q;
        status_word[mahi_pkg::ST_EXT_BIT]  = ext_q;
        status_word[mahi_pkg::ST_CS_BIT]   = steal_q;
        status_word[mahi_pkg::ST_SEQ_BIT]  = seq_q;
        status_word[mahi_pkg::ST_ATM_BIT]  = atm_q;
        status_word[mahi_pkg::ST_PGM_BIT]  = pgm_en_q;
        status_word[mahi_pkg::ST_PRI_BIT]  = pri_en_q;
        status_word[mahi_pkg::IS_BUF_BIT]  = buf_out_valid;
        status_word[mahi_pkg::IS_BUSY_BIT] = state_q != mahi_pkg::ST_IDLE;
        status_word[mahi_pkg::IS_DONE_BIT] = done_q;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        state_d     = state_q;
        chan_d      = chan_q;
        gain_d      = gain_q;
        ext_d       = ext_q;
        steal_d     = steal_q;
        seq_d       = seq_q;
        atm_d       = atm_q;
        pgm_en_d    = pgm_en_q;
        pri_en_d    = pri_en_q;
        start_d     = 1'b0;
        pend_d      = pend_q && !buf_in_ready;
        pend_data_d = pend_data_q;
        unique case (state_q)
            mahi_pkg::ST_IDLE:
            begin
            end
            mahi_pkg::ST_ARM:
            begin
                // wait for room so the result never overruns storage
                if (pace_ok && !pend_q && !start_q && sync_fire) // [R15] [R09]
                begin
                    start_d = 1'b1;
                    state_d = mahi_pkg::ST_CONV;
                end
            end
            mahi_pkg::ST_CONV:
            begin
                if (conv_done) // [R08]
                begin
                    pend_d      = 1'b1;
                    pend_data_d = {{(mahi_pkg::WORD_W - mahi_pkg::RESULT_W){conv_result[12]}}, conv_result}; // [R07]
                    if (steal_q && seq_q) // [R12]
                    begin
                        chan_d  = chan_q + 7'h01; // [R20]
                        state_d = mahi_pkg::ST_ARM;
                    end
                    else
                    begin
                        state_d = mahi_pkg::ST_IDLE;
                    end
                end
            end
        endcase
        if (cmd_start) // [R04]
        begin
            chan_d   = ac_in[mahi_pkg::ST_CHAN_LSB +: mahi_pkg::CHAN_W]; // [R05]
            gain_d   = ac_in[mahi_pkg::ST_GAIN_LSB +: mahi_pkg::GAIN_W]; // [R06]
            ext_d    = ac_in[mahi_pkg::ST_EXT_BIT];
            steal_d  = ac_in[mahi_pkg::ST_CS_BIT];
            seq_d    = ac_in[mahi_pkg::ST_SEQ_BIT];
            atm_d    = ac_in[mahi_pkg::ST_ATM_BIT]; // [R13]
            pgm_en_d = ac_in[mahi_pkg::ST_PGM_BIT];
            pri_en_d = ac_in[mahi_pkg::ST_PRI_BIT];
            state_d  = mahi_pkg::ST_ARM;
        end
        else if (cmd_clear)
        begin
            // clear also stops a free-running sequential scan
            state_d = (state_d == mahi_pkg::ST_CONV) ? mahi_pkg::ST_CONV : mahi_pkg::ST_IDLE;
            seq_d   = 1'b0;
        end
    end

    // ****************************************************************
    // next host-facing values
    // ****************************************************************
    always_comb
    begin
        done_d    = (done_q && !cmd_clear) || done_evt; // [R19]
        skip_d    = cmd_skip && done_q;                 // [R18]
        ac_vld_d  = cmd_read || cmd_status;             // [R10]
        ac_d      = ac_q;
        if (cmd_read)
        begin
            ac_d = buf_out_valid ? buf_out_data : mahi_pkg::WORD_RST; // [R10]
        end
        else if (cmd_status)
        begin
            ac_d = status_word; // [R10]
        end
        cs_req_d  = (cs_req_q && !cycle_steal_ack) || cs_take; // [R11]
        cs_data_d = cs_take ? buf_out_data : cs_data_q;
        cs_add_d  = cs_take ? atm_q : cs_add_q; // [R13]
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q     <= mahi_pkg::ST_IDLE;
            chan_q      <= mahi_pkg::CHAN_RST;
            gain_q      <= mahi_pkg::GAIN_RST;
            ext_q       <= 1'b0;
            steal_q     <= 1'b0;
            seq_q       <= 1'b0;
            atm_q       <= 1'b0;
            pgm_en_q    <= 1'b0;
            pri_en_q    <= 1'b0;
            done_q      <= 1'b0;
            start_q     <= 1'b0;
            sync_prev_q <= 1'b0;
            pend_q      <= 1'b0;
            pend_data_q <= mahi_pkg::WORD_RST;
            ac_q        <= mahi_pkg::WORD_RST;
            ac_vld_q    <= 1'b0;
            skip_q      <= 1'b0;
            pgm_irq_q   <= 1'b0;
            pri_irq_q   <= 1'b0;
            cs_req_q    <= 1'b0;
            cs_data_q   <= mahi_pkg::WORD_RST;
            cs_add_q    <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            chan_q      <= chan_d;
            gain_q      <= gain_d;
            ext_q       <= ext_d;
            steal_q     <= steal_d;
            seq_q       <= seq_d;
            atm_q       <= atm_d;
            pgm_en_q    <= pgm_en_d;
            pri_en_q    <= pri_en_d;
            done_q      <= done_d;
            start_q     <= start_d;
            sync_prev_q <= ext_sync;
            pend_q      <= pend_d;
            pend_data_q <= pend_data_d;
            ac_q        <= ac_d;
            ac_vld_q    <= ac_vld_d;
            skip_q      <= skip_d;
            pgm_irq_q   <= done_q && pgm_en_q; // [R14]
            pri_irq_q   <= done_q && pri_en_q; // [R14]
            cs_req_q    <= cs_req_d;
            cs_data_q   <= cs_data_d;
            cs_add_q    <= cs_add_d;
        end
    end

    assign ac_out             = ac_q;
    assign ac_out_valid       = ac_vld_q;
    assign skip_req           = skip_q;
    assign program_interrupt  = pgm_irq_q;
    assign priority_interrupt = pri_irq_q;
    assign cycle_steal_req    = cs_req_q;
    assign cycle_steal_data   = cs_data_q;
    assign cycle_steal_add    = cs_add_q;
    assign mux_channel        = chan_q;
    assign gain_sel           = gain_q;
    assign conv_start         = start_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [12:0] gap_q;

    always_ff @(posedge clk)
    begin
        if (rst || start_q)
        begin
            gap_q <= rst ? 13'h1FFF : 13'h0000; // no start yet counts as a long gap
        end
        else if (gap_q != 13'h1FFF)
        begin
            gap_q <= gap_q + 13'h0001;
        end
    end

    a_foreign_ignored: assert property (@(posedge clk) disable iff (rst) // [R01]
        (xfer_strobe && io_transfer_instruction[11:6] != mahi_pkg::DEVICE_CODE) |=> (!ac_vld_q && !skip_q))
        else $error("foreign device code answered");
    a_start_loads: assert property (@(posedge clk) disable iff (rst) // [R04]
        cmd_start |=> (chan_q == $past(ac_in[6:0]) && gain_q == $past(ac_in[8:7]) && state_q == mahi_pkg::ST_ARM))
        else $error("status word not applied");
    a_ext_sync_gate: assert property (@(posedge clk) disable iff (rst) // [R09]
        (start_q && ext_q) |-> ($past(ext_sync) && !$past(sync_prev_q)))
        else $error("external start without sync edge");
    a_start_spacing: assert property (@(posedge clk) disable iff (rst) // [R15]
        (start_q && $past(gap_q) != 13'h1FFF) |-> $past(gap_q) >= 13'(mahi_pkg::CONV_PERIOD_CYC - 1))
        else $error("converter restarted too soon");
    a_result_sign: assert property (@(posedge clk) disable iff (rst) // [R07]
        (conv_done && state_q == mahi_pkg::ST_CONV) |=> (pend_data_q[12:0] == $past(conv_result)
            && pend_data_q[17:13] == {5{pend_data_q[12]}}))
        else $error("result not sign extended");
    a_done_sticky: assert property (@(posedge clk) disable iff (rst) // [R19]
        (done_q && !cmd_clear) |=> done_q)
        else $error("done flag dropped");
    a_done_sets: assert property (@(posedge clk) disable iff (rst) // [R08]
        (done_evt ##1 (!cmd_clear && !cmd_start)) |-> (done_q ##1 (pgm_irq_q == pgm_en_q && pri_irq_q == pri_en_q)))
        else $error("done pulse lost");
    a_skip_answer: assert property (@(posedge clk) disable iff (rst) // [R18]
        cmd_skip |=> (skip_q == $past(done_q)))
        else $error("skip answer wrong");
    a_seq_step: assert property (@(posedge clk) disable iff (rst) // [R20]
        (done_evt && steal_q && seq_q && !cmd_start) |=> (chan_q == $past(chan_q) + 7'h01))
        else $error("channel not stepped");
    a_steal_hold: assert property (@(posedge clk) disable iff (rst) // [R11]
        (cs_req_q && !cycle_steal_ack) |=> (cs_req_q && $stable(cs_data_q) && $stable(cs_add_q)))
        else $error("cycle steal request dropped");

endmodule : mahi_top

// [sim/mahi_conv_model.sv]
`timescale 1ns/1ps
// ****************************************
// converter stand-in
// ****************************************
module mahi_conv_model
#(
    parameter int          DLY = 20,
    parameter logic [12:0] VAL = 13'h1F00
)
(
    input  wire logic        clk,
    input  wire logic        conv_start,
    output logic             conv_done,
    output logic      [12:0] conv_result
);
    int cnt = 0;
    initial conv_done = 1'b0;
    initial conv_result = 13'h0000;
    always @(posedge clk)
    begin
        conv_done <= (cnt == 1);
        // result only meaningful with done, so it toggles otherwise
        conv_result <= (cnt == 1) ? VAL : ~conv_result;
        if (conv_start)
            cnt <= DLY;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule : mahi_conv_model

// [sim/mahi_top_tb.sv]
`timescale 1ns/1ps
// ****************************************
// top bench
// ****************************************
module mahi_top_tb;
    localparam logic [5:0]  DEV = mahi_pkg::DEVICE_CODE;
    localparam logic [17:0] RES = 18'h3FF00;
    logic        clk;
    logic        rst;
    logic        xfer_strobe;
    logic [17:0] io_transfer_instruction;
    logic [17:0] ac_in;
    logic [17:0] ac_out;
    logic        ac_out_valid;
    logic        skip_req;
    logic        program_interrupt;
    logic        priority_interrupt;
    logic        cycle_steal_req;
    logic [17:0] cycle_steal_data;
    logic        cycle_steal_add;
    logic        cycle_steal_ack;
    logic [6:0]  mux_channel;
    logic [1:0]  gain_sel;
    logic        conv_start;
    logic        conv_done;
    logic [12:0] conv_result;
    logic        ext_sync;
    logic        pulse;
    logic [6:0]  ch;
    int          errors;
    int          num_checks;
    int          cyc;
    mahi_top u_mahi_top (.clk(clk), .rst(rst), .xfer_strobe(xfer_strobe),
        .io_transfer_instruction(io_transfer_instruction), .ac_in(ac_in), .ac_out(ac_out),
        .ac_out_valid(ac_out_valid), .skip_req(skip_req), .program_interrupt(program_interrupt),
        .priority_interrupt(priority_interrupt), .cycle_steal_req(cycle_steal_req),
        .cycle_steal_data(cycle_steal_data), .cycle_steal_add(cycle_steal_add),
        .cycle_steal_ack(cycle_steal_ack), .mux_channel(mux_channel), .gain_sel(gain_sel),
        .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result),
        .ext_sync(ext_sync));
    mahi_conv_model u_mahi_conv_model (.clk(clk), .conv_start(conv_start),
        .conv_done(conv_done), .conv_result(conv_result));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one strobed instruction; pulse holds the one-cycle answer
    task automatic xfer(input logic [5:0] dev, input logic [5:0] fn, input logic [17:0] d);
        @(posedge clk);
        xfer_strobe <= 1'b1;
        io_transfer_instruction <= {mahi_pkg::XFER_OPCODE, dev, fn};
        ac_in <= d;
        @(posedge clk);
        xfer_strobe <= 1'b0;
        #1;
        pulse = ac_out_valid | skip_req;
    endtask : xfer
    task automatic wait_for(input int sel, input int lim);
        int n;
        n = 0;
        while ((sel ? cycle_steal_req : program_interrupt) !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("wait", n < lim, 1'b1);
    endtask : wait_for
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            errors++;
            results();
        end
    end
    initial
    begin
        rst = 1'b1;
        xfer_strobe = 1'b0;
        io_transfer_instruction = 18'h00000;
        ac_in = 18'h00000;
        cycle_steal_ack = 1'b0;
        ext_sync = 1'b0;
        errors = 0;
        num_checks = 0;
        cyc = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        xfer(6'h0C, mahi_pkg::FN_STATUS, 18'h00000);
        chk("foreign", pulse, 1'b0);
        // program mode, channel 5, gain code 3, both interrupts on
        xfer(DEV, mahi_pkg::FN_START, 18'h06185);
        chk("chan", mux_channel, 7'h05);
        chk("gain", gain_sel, 2'h3);
        wait_for(0, 200);
        chk("prio", priority_interrupt, 1'b1);
        xfer(DEV, mahi_pkg::FN_SKIP, 18'h00000);
        chk("skip", pulse, 1'b1);
        xfer(DEV, mahi_pkg::FN_READ, 18'h00000);
        chk("result", ac_out, RES);
        xfer(DEV, mahi_pkg::FN_STATUS, 18'h00000);
        chk("done", ac_out[17], 1'b1);
        xfer(DEV, mahi_pkg::FN_CLEAR, 18'h00000);
        #10;
        chk("irq off", program_interrupt, 1'b0);
        xfer(DEV, mahi_pkg::FN_SKIP, 18'h00000);
        chk("noskip", pulse, 1'b0);
        // cycle steal, sequential from 126 with add; a long stall fills the buffer
        ch = 7'h7E;
        xfer(DEV, mahi_pkg::FN_START, 18'h01C7E);
        for (int i = 0; i < 4; i++)
        begin
            wait_for(1, 6000);
            if (i < 2)
                chk("seqchan", mux_channel, 7'(ch + 7'h01));
            ch = ch + 7'h01;
            chk("csdata", cycle_steal_data, RES);
            chk("csadd", cycle_steal_add, 1'b1);
            if (i == 1)
                repeat (10000) @(posedge clk);
            @(posedge clk);
            cycle_steal_ack <= 1'b1;
            @(posedge clk);
            cycle_steal_ack <= 1'b0;
            #1;
        end
        xfer(DEV, mahi_pkg::FN_CLEAR, 18'h00000);
        // random order, external sync: nothing starts before the sync edge
        xfer(DEV, mahi_pkg::FN_START, 18'h00615);
        repeat (3000) @(posedge clk);
        chk("nosync", cycle_steal_req, 1'b0);
        ext_sync <= 1'b1;
        wait_for(1, 200);
        ext_sync <= 1'b0;
        chk("randchan", mux_channel, 7'h15);
        chk("randdata", cycle_steal_data, RES);
        chk("noadd", cycle_steal_add, 1'b0);
        results();
    end
endmodule : mahi_top_tb
